// *** hw/aic_pkg.sv ***
// Constants, register map and state type of the analog interface controller
// Notes on behaviour
// - All logic runs on the bus clock.
// - Low reset input clears state asynchronously.
// - Five-bit bus address selects the register.
// - Transfers count only while select is high.
// - Second cycle with strobe is access phase.
// - Direction high writes, low reads a register.
// - Narrow bus uses write bits seven to zero.
// - Narrow bus drives only low read byte.
// - Fourteen event sources, each masked individually.
// - Interrupt active level set at build time.
// - Divider keeps config clock at or below ten megahertz.
// - Controller drives all config port signals.
// - Config port writes analog quad settings.
// - Sends control to converter, captures its status.
// - Conversions start only from register writes.
// - Optional queue holds up to 256 results.
package aic_pkg;

  localparam int          SYS_CLK_HZ     = 20_000_000;
  localparam int          CFG_CLK_MAX_HZ = 10_000_000;
  localparam int          CFG_DIV_MIN    = (SYS_CLK_HZ + CFG_CLK_MAX_HZ - 1) / CFG_CLK_MAX_HZ;
  localparam int          CFG_DIV_MAX    = 256;

  localparam int          QUEUE_DEPTH    = 256;
  localparam int          RESULT_W       = 12;
  localparam int          IRQ_W          = 14;

  // Register byte offsets; every register is one aligned 16-bit halfword
  localparam logic [4:0]  OFS_ADC_CTRL    = 5'h00;
  localparam logic [4:0]  OFS_CFG_ADDR    = 5'h02;
  localparam logic [4:0]  OFS_CFG_DATA    = 5'h04;
  localparam logic [4:0]  OFS_RESULT      = 5'h06;
  localparam logic [4:0]  OFS_RESULT_HI   = 5'h08;
  localparam logic [4:0]  OFS_STATUS      = 5'h0a;
  localparam logic [4:0]  OFS_ADC_STATUS  = 5'h0c;
  localparam logic [4:0]  OFS_QUEUE_COUNT = 5'h0e;
  localparam logic [4:0]  OFS_IRQ_STATUS  = 5'h10;
  localparam logic [4:0]  OFS_IRQ_STAT_HI = 5'h12;
  localparam logic [4:0]  OFS_IRQ_MASK    = 5'h14;
  localparam logic [4:0]  OFS_IRQ_MASK_HI = 5'h16;

  // Control register fields
  localparam int          CTRL_START_BIT  = 7;

  // Interrupt event positions
  localparam int          EV_CONV_DONE    = 0;
  localparam int          EV_CFG_DONE     = 1;
  localparam int          EV_QUEUE_FULL   = 2;
  localparam int          EV_QUEUE_OVF    = 3;
  localparam int          EV_QUEUE_UNF    = 4;
  localparam int          EV_START_REFUSE = 5;
  localparam int          EV_ADC_STAT_LO  = 6;

  typedef struct packed {
    logic [15:0]         prdata;
    logic                pready;
    logic [4:0]          chan;
    logic [1:0]          mode;
    logic                adc_start;
    logic                busy;
    logic [7:0]          cfg_addr_buf;
    logic [7:0]          cfg_data_buf;
    logic                cfg_pend;
    logic [7:0]          cfg_addr;
    logic [7:0]          cfg_wdata;
    logic                cfg_wen;
    logic                cfg_clk;
    logic [7:0]          cfg_cnt;
    logic [RESULT_W-1:0] last_result;
    logic [7:0]          q_rd;
    logic [7:0]          q_wr;
    logic [8:0]          q_cnt;
    logic [7:0]          adc_stat;
    logic [IRQ_W-1:0]    irq_stat;
    logic [IRQ_W-1:0]    irq_mask;
    logic                irq;
  } aic_state_t;

endpackage

// *** hw/aic_ctrl.sv ***
// APB controller for the analog block: converter control, result queue, config port, interrupt
`timescale 1ns/1ps
`default_nettype none

module aic_ctrl #(
  parameter bit WIDE_BUS_SELECT      = 1'b1,
  parameter bit IRQ_POLARITY_LOW     = 1'b0,
  parameter bit RESULT_QUEUE_OPTION  = 1'b1,
  parameter int CONFIG_CLOCK_DIVISOR = 2
) (
  input  wire logic                          clk_sys_i,
  input  wire logic                          rst_n_i,
  // APB slave
  input  wire logic [4:0]                    paddr_i,
  input  wire logic                          psel_i,
  input  wire logic                          penable_i,
  input  wire logic                          pwrite_i,
  input  wire logic [15:0]                   pwdata_i,
  output logic      [15:0]                   prdata_o,
  output logic                               pready_o,
  output logic                               irq_o,
  // Converter side
  output logic                               adc_start_o,
  output logic      [4:0]                    adc_channel_o,
  output logic      [1:0]                    adc_mode_o,
  input  wire logic                          adc_busy_i,
  input  wire logic                          adc_done_i,
  input  wire logic [aic_pkg::RESULT_W-1:0]  adc_result_i,
  input  wire logic [7:0]                    adc_status_i,
  // Analog configuration port
  output logic                               cfg_clk_o,
  output logic      [7:0]                    cfg_addr_o,
  output logic      [7:0]                    cfg_wdata_o,
  output logic                               cfg_wen_o
);
  import aic_pkg::*;

  // A divisor below the minimum would push the config clock past its limit
  localparam int         DIV_EFF  = (CONFIG_CLOCK_DIVISOR < CFG_DIV_MIN) ? CFG_DIV_MIN :
                                    (CONFIG_CLOCK_DIVISOR > CFG_DIV_MAX) ? CFG_DIV_MAX :
                                    CONFIG_CLOCK_DIVISOR;
  localparam logic [7:0] DIV_LAST = 8'(DIV_EFF - 1);
  localparam logic [7:0] DIV_HALF = 8'(DIV_EFF / 2);
  localparam logic       IRQ_IDLE = IRQ_POLARITY_LOW;

  localparam aic_state_t ST_RST = '{pready: 1'b1, irq: IRQ_IDLE, cfg_clk: 1'b1, default: '0};

  aic_state_t            q;
  aic_state_t            d;

  logic [RESULT_W-1:0]   q_mem [0:QUEUE_DEPTH-1];
  logic [RESULT_W-1:0]   head;
  logic [15:0]           wdat;
  logic [15:0]           rdata;
  logic [IRQ_W-1:0]      ev;
  logic [IRQ_W-1:0]      clr;
  logic                  setup;
  logic                  access;
  logic                  wr_acc;
  logic                  rd_acc;
  logic                  push;
  logic                  pop;
  logic                  q_empty;
  logic                  q_full;
  logic                  fall_en;

  // Narrow mode keeps only the low byte, in both directions
  function automatic logic [15:0] bus_fit(input logic [15:0] v);
    bus_fit = WIDE_BUS_SELECT ? v : {8'h00, v[7:0]};
  endfunction

  function automatic logic [15:0] zext14(input logic [IRQ_W-1:0] v);
    zext14 = {2'b00, v};
  endfunction

  // Queue pointers wrap on their own at the queue depth
  function automatic logic [7:0] ptr_next(input logic [7:0] p);
    ptr_next = p + 8'h01;
  endfunction

  assign q_empty = (q.q_cnt == 9'h000);
  assign q_full  = (q.q_cnt == 9'(QUEUE_DEPTH));

  // Empty queue reads zero rather than a stale slot
  always_comb begin
    if (RESULT_QUEUE_OPTION) begin
      head = q_empty ? '0 : q_mem[q.q_rd];
    end else begin
      head = q.last_result;
    end
  end

  always_comb begin
    rdata = 16'h0000;
    case (paddr_i)
      OFS_ADC_CTRL: begin
        rdata = {9'h000, q.mode, q.chan};
      end
      OFS_CFG_ADDR: begin
        rdata = {8'h00, q.cfg_addr_buf};
      end
      OFS_CFG_DATA: begin
        rdata = {8'h00, q.cfg_data_buf};
      end
      OFS_RESULT: begin
        rdata = {4'h0, head};
      end
      OFS_RESULT_HI: begin
        rdata = {12'h000, head[RESULT_W-1:8]};
      end
      OFS_STATUS: begin
        rdata = {12'h000, q.cfg_pend | q.cfg_wen, q_full, q_empty, q.busy};
      end
      OFS_ADC_STATUS: begin
        rdata = {8'h00, q.adc_stat};
      end
      OFS_QUEUE_COUNT: begin
        rdata = {7'h00, q.q_cnt};
      end
      OFS_IRQ_STATUS: begin
        rdata = zext14(q.irq_stat);
      end
      OFS_IRQ_STAT_HI: begin
        rdata = {10'h000, q.irq_stat[IRQ_W-1:8]};
      end
      OFS_IRQ_MASK: begin
        rdata = zext14(q.irq_mask);
      end
      OFS_IRQ_MASK_HI: begin
        rdata = {10'h000, q.irq_mask[IRQ_W-1:8]};
      end
      default: begin
        rdata = 16'h0000;
      end
    endcase
  end

  always_comb begin
    d      = q;
    ev     = '0;
    clr    = '0;
    push   = 1'b0;
    pop    = 1'b0;
    setup  = psel_i & ~penable_i;
    access = psel_i & penable_i;
    wr_acc = access & pwrite_i;
    rd_acc = access & ~pwrite_i;
    wdat   = bus_fit(pwdata_i);

    d.adc_start = 1'b0;
    d.pready    = 1'b1;

    // Read data is sampled in the setup cycle so the access phase needs no wait state
    if (setup & ~pwrite_i) begin
      d.prdata = bus_fit(rdata);
    end

    // Config port clock: high for the first half of each divider period
    if (q.cfg_cnt == DIV_LAST) begin
      d.cfg_cnt = 8'h00;
    end else begin
      d.cfg_cnt = q.cfg_cnt + 8'h01;
    end
    d.cfg_clk = (d.cfg_cnt < DIV_HALF);
    fall_en   = (d.cfg_cnt == DIV_HALF);

    // Port signals change only on the falling config edge, so each is stable at the rising one
    if (fall_en) begin
      if (q.cfg_wen) begin
        d.cfg_wen = 1'b0;
        ev[EV_CFG_DONE] = 1'b1;
      end else if (q.cfg_pend) begin
        d.cfg_wen   = 1'b1;
        d.cfg_addr  = q.cfg_addr_buf;
        d.cfg_wdata = q.cfg_data_buf;
        d.cfg_pend  = 1'b0;
      end
    end

    if (wr_acc) begin
      case (paddr_i)
        OFS_ADC_CTRL: begin
          d.chan = wdat[4:0];
          d.mode = wdat[6:5];
          if (wdat[CTRL_START_BIT]) begin
            if (q.busy | adc_busy_i) begin
              ev[EV_START_REFUSE] = 1'b1;
            end else begin
              d.adc_start = 1'b1;
              d.busy      = 1'b1;
            end
          end
        end
        OFS_CFG_ADDR: begin
          d.cfg_addr_buf = wdat[7:0];
        end
        OFS_CFG_DATA: begin
          // A second write before launch replaces the pending byte
          d.cfg_data_buf = wdat[7:0];
          d.cfg_pend     = 1'b1;
        end
        OFS_IRQ_STATUS: begin
          clr = wdat[IRQ_W-1:0];
        end
        OFS_IRQ_STAT_HI: begin
          clr[IRQ_W-1:8] = wdat[IRQ_W-9:0];
        end
        OFS_IRQ_MASK: begin
          if (WIDE_BUS_SELECT) begin
            d.irq_mask = wdat[IRQ_W-1:0];
          end else begin
            d.irq_mask[7:0] = wdat[7:0];
          end
        end
        OFS_IRQ_MASK_HI: begin
          d.irq_mask[IRQ_W-1:8] = wdat[IRQ_W-9:0];
        end
        default: begin
        end
      endcase
    end

    // Reading the result word consumes one queue entry
    if (rd_acc && (paddr_i == OFS_RESULT) && RESULT_QUEUE_OPTION) begin
      if (q_empty) begin
        ev[EV_QUEUE_UNF] = 1'b1;
      end else begin
        pop    = 1'b1;
        d.q_rd = ptr_next(q.q_rd);
      end
    end

    if (adc_done_i) begin
      d.busy = 1'b0;
      ev[EV_CONV_DONE] = 1'b1;
      if (RESULT_QUEUE_OPTION) begin
        if (q_full && !pop) begin
          ev[EV_QUEUE_OVF] = 1'b1;
        end else begin
          push   = 1'b1;
          d.q_wr = ptr_next(q.q_wr);
        end
      end else begin
        d.last_result = adc_result_i;
      end
    end

    d.q_cnt = q.q_cnt + 9'(push) - 9'(pop);
    if (push && !pop && (q.q_cnt == 9'(QUEUE_DEPTH - 1))) begin
      ev[EV_QUEUE_FULL] = 1'b1;
    end

    // Rising edges of the returned converter status are events of their own
    d.adc_stat = adc_status_i;
    ev[IRQ_W-1:EV_ADC_STAT_LO] = adc_status_i & ~q.adc_stat;

    // A new event in the cycle of its clear stays set
    d.irq_stat = (q.irq_stat & ~clr) | ev;
    d.irq      = (|(d.irq_stat & d.irq_mask)) ^ IRQ_POLARITY_LOW;
  end

  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q <= ST_RST;
    end else begin
      q <= d;
    end
  end

  // Queue storage carries no reset; occupancy is tracked by the entry count
  always_ff @(posedge clk_sys_i) begin
    if (push) begin
      q_mem[q.q_wr] <= adc_result_i;
    end
  end

  assign prdata_o      = q.prdata;
  assign pready_o      = q.pready;
  assign irq_o         = q.irq;
  assign adc_start_o   = q.adc_start;
  assign adc_channel_o = q.chan;
  assign adc_mode_o    = q.mode;
  assign cfg_clk_o     = q.cfg_clk;
  assign cfg_addr_o    = q.cfg_addr;
  assign cfg_wdata_o   = q.cfg_wdata;
  assign cfg_wen_o     = q.cfg_wen;

endmodule

`default_nettype wire

// *** bench/aic_ctrl_sva.sv ***
// Port-level checks of the analog interface controller
`timescale 1ns/1ps
`default_nettype none
module aic_ctrl_sva
  import aic_pkg::*;
#(
  parameter int CONFIG_CLOCK_DIVISOR = 2
) (
  input wire logic        clk_sys_i,
  input wire logic        rst_n_i,
  input wire logic [4:0]  paddr_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [15:0] pwdata_i,
  input wire logic [15:0] prdata_o,
  input wire logic        adc_start_o,
  input wire logic [4:0]  adc_channel_o,
  input wire logic        adc_busy_i,
  input wire logic        cfg_clk_o,
  input wire logic        cfg_wen_o
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  AST_START_PULSE: assert property (adc_start_o |=> !adc_start_o)
    else $error("start pulse longer than one cycle");
  AST_START_CAUSE: assert property ($rose(adc_start_o) |->
    $past(psel_i && penable_i && pwrite_i && paddr_i == OFS_ADC_CTRL && pwdata_i[7]))
    else $error("start without a start write");
  AST_START_IDLE: assert property ($rose(adc_start_o) |-> !$past(adc_busy_i))
    else $error("start while converter busy");
  AST_CHANNEL: assert property ($rose(adc_start_o) |-> adc_channel_o == $past(pwdata_i[4:0]))
    else $error("channel not taken from start write");
  // The release edge still shows the reset clock level, so start only once out of reset
  AST_CFG_CLK: assert property (rst_n_i && (CONFIG_CLOCK_DIVISOR == 2) |=>
    cfg_clk_o != $past(cfg_clk_o))
    else $error("config clock not at half rate");
  AST_WEN_FALL: assert property ($rose(cfg_wen_o) |-> $fell(cfg_clk_o))
    else $error("config write not launched on falling config clock");
  AST_WEN_LEN: assert property ((CONFIG_CLOCK_DIVISOR == 2) && $rose(cfg_wen_o) |=>
    cfg_wen_o ##1 !cfg_wen_o)
    else $error("config write strobe length wrong");
  AST_RDATA_HOLD: assert property (!(psel_i && !penable_i && !pwrite_i) |=> $stable(prdata_o))
    else $error("read data changed outside a read setup");
endmodule
bind aic_ctrl aic_ctrl_sva #(.CONFIG_CLOCK_DIVISOR(CONFIG_CLOCK_DIVISOR)) u_sva (
  .clk_sys_i, .rst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o,
  .adc_start_o, .adc_channel_o, .adc_busy_i, .cfg_clk_o, .cfg_wen_o);
`default_nettype wire

// *** bench/aic_adc_model.sv ***
// Behavioural converter answering each start after a fixed latency
`timescale 1ns/1ps
`default_nettype none
module aic_adc_model #(
  parameter int LATENCY = 8
) (
  input  wire logic       clk_sys_i,
  input  wire logic       rst_n_i,
  input  wire logic       start_i,
  input  wire logic [4:0] chan_i,
  output logic            busy_o,
  output logic            done_o,
  output logic [11:0]     result_o
);
  int          cnt;
  logic [11:0] val;
  // Outside the done cycle the result bus shows garbage, not the last value
  assign result_o = done_o ? val : ~val;
  always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cnt <= 0;
      busy_o <= 1'b0;
      done_o <= 1'b0;
      val <= '0;
    end else begin
      done_o <= 1'b0;
      if (start_i && !busy_o) begin
        busy_o <= 1'b1;
        cnt <= LATENCY;
        val <= {7'h5a, chan_i};
      end else if (busy_o) begin
        cnt <= cnt - 1;
        if (cnt == 1) begin
          busy_o <= 1'b0;
          done_o <= 1'b1;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** bench/aic_ctrl_bench.sv ***
// Self-checking bench for the analog interface controller
`timescale 1ns/1ps
`default_nettype none
`define CHK(got, exp) begin num_checks++; if ((got) !== (exp)) begin mismatches++; \
  $display("mismatch at %0t: got %h expected %h", $time, got, exp); end end
module aic_ctrl_bench;
  import aic_pkg::*;
  logic        clk_sys_i = 1'b0;
  logic        rst_n_i = 1'b0;
  logic [4:0]  paddr_i = '0;
  logic        psel_i = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i = 1'b0;
  logic [15:0] pwdata_i = '0;
  logic [7:0]  adc_status_i = '0;
  logic [15:0] prdata_o, rd;
  logic        pready_o, irq_o, adc_start_o, adc_busy_i, adc_done_i, cfg_clk_o, cfg_wen_o;
  logic [4:0]  adc_channel_o;
  logic [1:0]  adc_mode_o;
  logic [11:0] adc_result_i;
  logic [7:0]  cfg_addr_o, cfg_wdata_o;
  int          mismatches = 0;
  int          num_checks = 0;

  aic_ctrl uut (.clk_sys_i, .rst_n_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i,
    .prdata_o, .pready_o, .irq_o, .adc_start_o, .adc_channel_o, .adc_mode_o, .adc_busy_i,
    .adc_done_i, .adc_result_i, .adc_status_i, .cfg_clk_o, .cfg_addr_o, .cfg_wdata_o, .cfg_wen_o);
  aic_adc_model u_adc (.clk_sys_i, .rst_n_i, .start_i(adc_start_o), .chan_i(adc_channel_o),
    .busy_o(adc_busy_i), .done_o(adc_done_i), .result_o(adc_result_i));

  initial begin
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  task automatic tally_and_finish();
    if (mismatches == 0 && num_checks > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  task automatic ran_out();
    mismatches++;
    $display("mismatch at %0t: wait ran out", $time);
    tally_and_finish();
  endtask

  task automatic cycles(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask

  task automatic apb(input logic w, input logic [4:0] a, input logic [15:0] d);
    int n;
    @(posedge clk_sys_i);
    psel_i <= 1'b1;
    pwrite_i <= w;
    paddr_i <= a;
    pwdata_i <= d;
    @(posedge clk_sys_i);
    penable_i <= 1'b1;
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (pready_o !== 1'b1 && n < 50);
    if (n >= 50) ran_out();
    rd = prdata_o;
    psel_i <= 1'b0;
    penable_i <= 1'b0;
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    apb(1'b1, a, d);
  endtask

  task automatic rdc(input logic [4:0] a, input logic [15:0] exp);
    apb(1'b0, a, 16'h0000);
    `CHK(rd, exp)
  endtask

  task automatic t_reset();
    `CHK(irq_o, 1'b0)
    `CHK(cfg_wen_o, 1'b0)
    `CHK(pready_o, 1'b1)
    rdc(OFS_IRQ_MASK, 16'h0000);
    rdc(5'h1e, 16'h0000);
    rdc(5'h01, 16'h0000);
  endtask

  task automatic t_conv();
    int n;
    wr(OFS_ADC_CTRL, 16'h00c5);
    cycles(1);
    `CHK(adc_start_o, 1'b1)
    `CHK(adc_channel_o, 5'h05)
    `CHK(adc_mode_o, 2'h2)
    // Second start lands while the first is still converting
    wr(OFS_ADC_CTRL, 16'h0081);
    n = 0;
    do begin
      apb(1'b0, OFS_STATUS, 16'h0000);
      n++;
    end while (rd[0] !== 1'b0 && n < 40);
    if (n >= 40) ran_out();
    rdc(OFS_QUEUE_COUNT, 16'h0001);
    rdc(OFS_RESULT_HI, 16'h000b);
    rdc(OFS_RESULT, 16'h0b45);
    rdc(OFS_QUEUE_COUNT, 16'h0000);
    // Reading the empty queue yields zero and raises the underflow event
    rdc(OFS_RESULT, 16'h0000);
    rdc(OFS_IRQ_STATUS, 16'h0031);
  endtask

  task automatic t_irq();
    `CHK(irq_o, 1'b0)
    wr(OFS_IRQ_MASK, 16'h0020);
    cycles(1);
    `CHK(irq_o, 1'b1)
    wr(OFS_IRQ_STATUS, 16'h0020);
    cycles(1);
    `CHK(irq_o, 1'b0)
    rdc(OFS_IRQ_STATUS, 16'h0011);
    adc_status_i <= 8'h80;
    cycles(3);
    rdc(OFS_IRQ_STATUS, 16'h2011);
    rdc(OFS_IRQ_STAT_HI, 16'h0020);
    wr(OFS_IRQ_MASK, 16'h2000);
    cycles(1);
    `CHK(irq_o, 1'b1)
    wr(OFS_IRQ_STATUS, 16'h3fff);
    cycles(1);
    `CHK(irq_o, 1'b0)
  endtask

  task automatic t_unsel();
    @(posedge clk_sys_i);
    pwrite_i <= 1'b1;
    paddr_i <= OFS_IRQ_MASK;
    pwdata_i <= 16'h3fff;
    penable_i <= 1'b1;
    cycles(2);
    penable_i <= 1'b0;
    pwrite_i <= 1'b0;
    rdc(OFS_IRQ_MASK, 16'h2000);
  endtask

  task automatic t_cfg();
    int n;
    wr(OFS_CFG_ADDR, 16'h005a);
    wr(OFS_CFG_DATA, 16'h00c3);
    n = 0;
    do begin
      @(posedge clk_sys_i);
      n++;
    end while (cfg_wen_o !== 1'b1 && n < 20);
    if (n >= 20) ran_out();
    `CHK(cfg_addr_o, 8'h5a)
    `CHK(cfg_wdata_o, 8'hc3)
    cycles(4);
    rdc(OFS_CFG_ADDR, 16'h005a);
    rdc(OFS_IRQ_STATUS, 16'h0002);
  endtask

  initial begin
    repeat (5) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    cycles(1);
    t_reset();
    t_conv();
    t_irq();
    t_unsel();
    t_cfg();
    tally_and_finish();
  end
endmodule
`default_nettype wire
